/* verilog/trct_pkg.sv */
package trct_pkg;

    // ****************************************************************
    // command codes of the bank
    // ****************************************************************
    localparam logic [7:0]  CMD_WARM_T6    = 8'h24;
    localparam logic [7:0]  CMD_VCODE_65   = 8'h25;
    localparam logic [7:0]  CMD_VCODE_432  = 8'h26;
    localparam logic [7:0]  CMD_ICODE_65   = 8'h27;
    localparam logic [7:0]  CMD_CHG_CFG    = 8'h29;

    // ****************************************************************
    // widths, field positions and reset values
    // ****************************************************************
    localparam int          CODE_W         = 5;
    localparam int          LSB_LOW        = 0;
    localparam int          LSB_MID        = 5;
    localparam int          LSB_HIGH       = 10;
    localparam int          CFG_EN_BIT     = 0;
    localparam logic signed [15:0] RST_T6  = 16'h136a;  // 4970
    localparam logic [9:0]  RST_V65        = 10'h067;   // 103
    localparam logic [14:0] RST_V432       = 15'h1def;  // 7663
    localparam logic [9:0]  RST_I65        = 10'h1ef;   // 495
    localparam logic [2:0]  RST_CFG        = 3'h1;
    localparam logic [4:0]  RST_V6         = 5'h03;
    localparam logic [4:0]  RST_V5         = 5'h07;
    localparam logic [4:0]  RST_V4         = 5'h07;
    localparam logic [4:0]  RST_V3         = 5'h0f;
    localparam logic [4:0]  RST_V2         = 5'h0f;
    localparam logic [4:0]  RST_I6         = 5'h0f;
    localparam logic [4:0]  RST_I5         = 5'h0f;

    // ****************************************************************
    // code encodings, used by the analog servo outside this block
    // ****************************************************************
    localparam int          VSTEP_UV       = 12500;   // per code, per cell
    localparam int          VOFS_UV        = 3412500; // code zero, per cell
    localparam int          ISTEP_UV       = 1000;    // (code + 1) times

    // ****************************************************************
    // temperature regions, gray coded from cold to hot
    // ****************************************************************
    typedef enum logic [2:0]
    {
        REG_R1 = 3'b000,
        REG_R2 = 3'b001,
        REG_R3 = 3'b011,
        REG_R4 = 3'b010,
        REG_R5 = 3'b110,
        REG_R6 = 3'b111,
        REG_R7 = 3'b101
    } trct_region_t;

    localparam trct_region_t RST_REGION    = REG_R4;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } trct_cmd_t;

    typedef struct packed
    {
        logic        valid;
        logic        miss;
        logic [15:0] data;
    } trct_rsp_t;

    typedef struct packed
    {
        logic signed [15:0] t1;
        logic signed [15:0] t2;
        logic signed [15:0] t3;
        logic signed [15:0] t4;
        logic signed [15:0] t5;
    } trct_thr_t;

    typedef struct packed
    {
        logic [4:0] i4;
        logic [4:0] i3;
        logic [4:0] i2;
    } trct_icode_t;

    typedef struct packed
    {
        logic [4:0] vcode;
        logic [4:0] icode;
        logic       suspend;
        logic       jeita;
    } trct_tgt_t;

    // five-bit code field at a given position of a register
    function automatic logic [4:0] code_at(logic [15:0] r, int lsb);
        return r[lsb +: CODE_W];
    endfunction

endpackage

/* verilog/trct_region_sense.sv */
`timescale 1ns/100ps
module trct_region_sense
(
    input  wire logic                clock,        // system clock
    input  wire logic                rst,          // sync reset, high
    input  wire logic                temp_valid,   // new telemetry word
    input  wire logic signed [15:0]  temp_value,   // thermistor reading
    input  wire trct_pkg::trct_thr_t thr,          // thresholds t1..t5
    input  wire logic signed [15:0]  t6,           // warm-end threshold
    output logic signed [15:0]       sample_q,     // latest reading
    output logic                     seen_q,       // a reading arrived
    output trct_pkg::trct_region_t   region_q      // present region
);
    import trct_pkg::*;

    logic signed [15:0] sample_d;
    logic               seen_d;
    trct_region_t       region_d;

    // larger reading is colder, so compare from the cold end down
    always_comb
    begin
        sample_d = temp_valid ? temp_value : sample_q;
        seen_d   = seen_q | temp_valid;
        region_d = region_q;
        if (seen_d)
        begin
            if (sample_d > thr.t1)      region_d = REG_R1;
            else if (sample_d > thr.t2) region_d = REG_R2;
            else if (sample_d > thr.t3) region_d = REG_R3;
            else if (sample_d > thr.t4) region_d = REG_R4;
            else if (sample_d > thr.t5) region_d = REG_R5;
            else if (sample_d > t6)     region_d = REG_R6;
            else                        region_d = REG_R7;
        end
    end

    // region held at its reset value until the first reading
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sample_q <= 16'h0000;
            seen_q   <= 1'b0;
            region_q <= RST_REGION;
        end
        else
        begin
            sample_q <= sample_d;
            seen_q   <= seen_d;
            region_q <= region_d;
        end
    end

endmodule

/* verilog/trct_target_select.sv */
`timescale 1ns/100ps
module trct_target_select
(
    input  wire logic                  clock,     // system clock
    input  wire logic                  rst,       // sync reset, high
    input  wire trct_pkg::trct_region_t region,   // present region
    input  wire logic                  jeita_en,  // qualified charging on
    input  wire logic [9:0]            v65,       // region 6/5 volt codes
    input  wire logic [14:0]           v432,      // region 4/3/2 codes
    input  wire logic [9:0]            i65,       // region 6/5 currents
    input  wire trct_pkg::trct_icode_t i432,      // region 4/3/2 currents
    input  wire logic [4:0]            vset,      // host voltage code
    input  wire logic [4:0]            iset,      // host current code
    output trct_pkg::trct_tgt_t        tgt_q      // active targets
);
    import trct_pkg::*;

    trct_tgt_t tgt_d;

    // host codes pass unless a region code is substituted
    always_comb
    begin
        tgt_d.vcode   = vset;
        tgt_d.icode   = iset;
        tgt_d.suspend = 1'b0;
        tgt_d.jeita   = jeita_en;
        if (jeita_en)
        begin
            case (region)
                REG_R2:
                begin
                    tgt_d.vcode = code_at(16'(v432), LSB_LOW);
                    tgt_d.icode = i432.i2;
                end
                REG_R3:
                begin
                    tgt_d.vcode = code_at(16'(v432), LSB_MID);
                    tgt_d.icode = i432.i3;
                end
                REG_R4:
                begin
                    tgt_d.vcode = code_at(16'(v432), LSB_HIGH);
                    tgt_d.icode = i432.i4;
                end
                REG_R5:
                begin
                    tgt_d.vcode = code_at(16'(v65), LSB_LOW);
                    tgt_d.icode = code_at(16'(i65), LSB_LOW);
                end
                REG_R6:
                begin
                    tgt_d.vcode = code_at(16'(v65), LSB_MID);
                    tgt_d.icode = code_at(16'(i65), LSB_MID);
                end
                // too cold or too hot: no charging at all
                default: tgt_d.suspend = 1'b1;
            endcase
        end
    end

    // registered so the servo never sees a decode glitch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tgt_q <= '0;
        end
        else
        begin
            tgt_q <= tgt_d;
        end
    end

endmodule

/* verilog/trct_region_targets.sv */
//Function
//- signed warm-end threshold, code 24h, reset 4970
//- larger reading means colder region
//- region six voltage code, bits 9:5
//- region five voltage code, bits 4:0
//- region four voltage code, bits 14:10
//- region three voltage code, bits 9:5
//- region two voltage code, bits 4:0, reset 15
//- region six current code, bits 9:5
//- region five current code, bits 4:0
//- region codes apply only while enabled
//- otherwise host voltage code stays active
`timescale 1ns/100ps
module trct_region_targets
(
    input  wire logic                  clock,        // system clock
    input  wire logic                  rst,          // sync reset, high
    input  wire trct_pkg::trct_cmd_t   cmd,          // command access
    output trct_pkg::trct_rsp_t        rsp_q,        // read answer
    input  wire logic                  temp_valid,   // telemetry strobe
    input  wire logic signed [15:0]    temp_value,   // thermistor word
    input  wire trct_pkg::trct_thr_t   thr_in,       // thresholds t1..t5
    input  wire trct_pkg::trct_icode_t icode_low,    // region 4/3/2 amps
    input  wire logic [4:0]            vcharge_set,  // host volt code
    input  wire logic [4:0]            icharge_set,  // host amp code
    output trct_pkg::trct_region_t     region,       // present region
    output trct_pkg::trct_tgt_t        targets       // active targets
);
    import trct_pkg::*;

    // ****************************************************************
    // register bank
    // ****************************************************************
    logic signed [15:0] t6_q;
    logic signed [15:0] t6_d;
    logic [9:0]         v65_q;
    logic [9:0]         v65_d;
    logic [14:0]        v432_q;
    logic [14:0]        v432_d;
    logic [9:0]         i65_q;
    logic [9:0]         i65_d;
    logic [2:0]         cfg_q;
    logic [2:0]         cfg_d;
    logic               wr_en;

    assign wr_en = cmd.valid & cmd.write;

    // write decode; unknown codes are dropped without effect
    always_comb
    begin
        t6_d   = t6_q;
        v65_d  = v65_q;
        v432_d = v432_q;
        i65_d  = i65_q;
        cfg_d  = cfg_q;
        if (wr_en && cmd.code == CMD_WARM_T6)
            t6_d = cmd.wdata;
        else if (wr_en && cmd.code == CMD_VCODE_65)
            v65_d = cmd.wdata[9:0];
        else if (wr_en && cmd.code == CMD_VCODE_432)
            v432_d = cmd.wdata[14:0];
        else if (wr_en && cmd.code == CMD_ICODE_65)
            i65_d = cmd.wdata[9:0];
        else if (wr_en && cmd.code == CMD_CHG_CFG)
            cfg_d = cmd.wdata[2:0];
    end

    // defaults land on the first edge with reset high
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            t6_q   <= RST_T6;
            v65_q  <= RST_V65;
            v432_q <= RST_V432;
            i65_q  <= RST_I65;
            cfg_q  <= RST_CFG;
        end
        else
        begin
            t6_q   <= t6_d;
            v65_q  <= v65_d;
            v432_q <= v432_d;
            i65_q  <= i65_d;
            cfg_q  <= cfg_d;
        end
    end

    // ****************************************************************
    // read answer
    // ****************************************************************
    trct_rsp_t rsp_d;

    // one cycle after the command; narrow registers zero-extended
    always_comb
    begin
        rsp_d.valid = cmd.valid & ~cmd.write;
        rsp_d.miss  = 1'b0;
        rsp_d.data  = 16'h0000;
        if (cmd.code == CMD_WARM_T6)
            rsp_d.data = t6_q;
        else if (cmd.code == CMD_VCODE_65)
            rsp_d.data = 16'(v65_q);
        else if (cmd.code == CMD_VCODE_432)
            rsp_d.data = 16'(v432_q);
        else if (cmd.code == CMD_ICODE_65)
            rsp_d.data = 16'(i65_q);
        else if (cmd.code == CMD_CHG_CFG)
            rsp_d.data = 16'(cfg_q);
        else
            rsp_d.miss = cmd.valid & ~cmd.write;
        if (!cmd.valid || cmd.write)
            rsp_d.data = 16'h0000;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // ****************************************************************
    // region and target logic
    // ****************************************************************
    logic signed [15:0] sample;
    logic               seen;

    trct_region_sense u_sense
    (
        .clock      (clock),
        .rst        (rst),
        .temp_valid (temp_valid),
        .temp_value (temp_value),
        .thr        (thr_in),
        .t6         (t6_q),
        .sample_q   (sample),
        .seen_q     (seen),
        .region_q   (region)
    );

    trct_target_select u_select
    (
        .clock    (clock),
        .rst      (rst),
        .region   (region),
        .jeita_en (cfg_q[CFG_EN_BIT]),
        .v65      (v65_q),
        .v432     (v432_q),
        .i65      (i65_q),
        .i432     (icode_low),
        .vset     (vcharge_set),
        .iset     (icharge_set),
        .tgt_q    (targets)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_t6_read;
        cmd.valid && !cmd.write && cmd.code == CMD_WARM_T6;
    endsequence

    sequence s_first_after_reset;
        $past(rst);
    endsequence

    AST_T6_RESET: assert property (s_first_after_reset |->
        t6_q == RST_T6)
        else $error("warm threshold reset value wrong");

    AST_T6_READBACK: assert property (s_t6_read |=>
        rsp_q.valid && !rsp_q.miss && rsp_q.data == $past(t6_q))
        else $error("warm threshold readback wrong");

    AST_COLD_END: assert property (
        seen && !temp_valid && sample > thr_in.t1 |=> region == REG_R1)
        else $error("coldest reading not in region one");

    AST_HOT_END: assert property (
        seen && !temp_valid && sample <= t6_q && sample <= thr_in.t5
        && sample <= thr_in.t4 && sample <= thr_in.t3
        && sample <= thr_in.t2 && sample <= thr_in.t1
        |=> region == REG_R7)
        else $error("reading at warm threshold not in region seven");

    AST_V6_RESET: assert property (s_first_after_reset |->
        v65_q[9:5] == RST_V6)
        else $error("region six voltage reset wrong");

    AST_V65_RESET: assert property (s_first_after_reset |->
        v65_q == RST_V65 && v65_q[4:0] == RST_V5)
        else $error("region six five voltage register reset wrong");

    AST_V432_WRITE: assert property (
        wr_en && cmd.code == CMD_VCODE_432 |=>
        v432_q == $past(cmd.wdata[14:0]) && rsp_q.data == 16'h0000)
        else $error("region four three two write lost");

    AST_V432_RESET: assert property (s_first_after_reset |->
        v432_q[14:10] == RST_V4 && v432_q[9:5] == RST_V3
        && v432_q == RST_V432)
        else $error("region four three two reset wrong");

    AST_I65_RESET: assert property (s_first_after_reset |->
        i65_q[9:5] == RST_I6 && i65_q[4:0] == RST_I5)
        else $error("region six five current reset wrong");

    AST_DISABLED_PASS: assert property (
        !cfg_q[CFG_EN_BIT] |=> targets.vcode == $past(vcharge_set)
        && targets.icode == $past(icharge_set) && !targets.suspend)
        else $error("host codes not passed while disabled");

    AST_SUSPEND_HOST_V: assert property (
        cfg_q[CFG_EN_BIT] && (region == REG_R1 || region == REG_R7)
        |=> targets.suspend && targets.vcode == $past(vcharge_set))
        else $error("out-of-range region not suspended");

    AST_R6_TARGETS: assert property (
        cfg_q[CFG_EN_BIT] && region == REG_R6 |=>
        targets.vcode == $past(v65_q[9:5])
        && targets.icode == $past(i65_q[9:5]))
        else $error("region six targets not applied");

    AST_R5_TARGETS: assert property (
        cfg_q[CFG_EN_BIT] && region == REG_R5 |=>
        targets.vcode == $past(v65_q[4:0])
        && targets.icode == $past(i65_q[4:0]) && targets.jeita)
        else $error("region five targets not applied");

    AST_STROBE_TO_TGT: assert property (
        temp_valid && cfg_q[CFG_EN_BIT] && temp_value <= t6_q
        && temp_value <= thr_in.t5 && temp_value <= thr_in.t4
        && temp_value <= thr_in.t3 && temp_value <= thr_in.t2
        && temp_value <= thr_in.t1
        ##1 cfg_q[CFG_EN_BIT] |=> targets.suspend)
        else $error("hot reading did not suspend within two cycles");

    AST_MISS_FLAG: assert property (
        cmd.valid && !cmd.write && cmd.code == 8'h28 |=>
        rsp_q.miss && rsp_q.data == 16'h0000)
        else $error("unmapped read not flagged");

    // writes and idle cycles must leave the answer port quiet
    AST_WRITE_SILENT: assert property (
        cmd.valid && cmd.write |=> !rsp_q.valid && !rsp_q.miss)
        else $error("write produced a read answer");

    AST_IDLE_QUIET: assert property (
        !cmd.valid |=> !rsp_q.valid && !rsp_q.miss && rsp_q.data == 16'h0000)
        else $error("idle cycle produced an answer");

    // each mapped code lands in its own register, high bits dropped
    AST_T6_WRITE: assert property (
        wr_en && cmd.code == CMD_WARM_T6 |=> t6_q == $past(cmd.wdata))
        else $error("warm threshold write lost");

    AST_V65_WRITE: assert property (
        wr_en && cmd.code == CMD_VCODE_65 |=> v65_q == $past(cmd.wdata[9:0]))
        else $error("region six five voltage write lost");

    AST_I65_WRITE: assert property (
        wr_en && cmd.code == CMD_ICODE_65 |=> i65_q == $past(cmd.wdata[9:0]))
        else $error("region six five current write lost");

    AST_CFG_WRITE: assert property (
        wr_en && cmd.code == CMD_CHG_CFG |=> cfg_q == $past(cmd.wdata[2:0]))
        else $error("charger configuration write lost");

    // no write, no change: the bank has no hardware-set bits
    AST_BANK_HOLD: assert property (
        !wr_en |=> $stable(t6_q) && $stable(v65_q) && $stable(v432_q)
        && $stable(i65_q) && $stable(cfg_q))
        else $error("register changed without a write");

    // region stays at its reset value until a reading arrives
    AST_NO_SAMPLE_HOLD: assert property (
        !seen && !temp_valid |=> region == RST_REGION)
        else $error("region moved before first reading");

    AST_EN_FLAG: assert property (
        cfg_q[CFG_EN_BIT] |=> targets.jeita)
        else $error("enable not reflected in targets");

    // regions two to four take currents from the level inputs
    AST_R4_TARGETS: assert property (
        cfg_q[CFG_EN_BIT] && region == REG_R4 |=>
        targets.vcode == $past(v432_q[14:10])
        && targets.icode == $past(icode_low.i4) && targets.jeita)
        else $error("region four targets not applied");

    AST_R3_TARGETS: assert property (
        cfg_q[CFG_EN_BIT] && region == REG_R3 |=>
        targets.vcode == $past(v432_q[9:5])
        && targets.icode == $past(icode_low.i3) && !targets.suspend)
        else $error("region three targets not applied");

    AST_R2_TARGETS: assert property (
        cfg_q[CFG_EN_BIT] && region == REG_R2 |=>
        targets.vcode == $past(v432_q[4:0])
        && targets.icode == $past(icode_low.i2) && !targets.suspend)
        else $error("region two targets not applied");

endmodule

/* sim/trct_host_model.sv */
`timescale 1ns/100ps
// ********************************************************************
// host side of the decoded command port
// ********************************************************************
module trct_host_model
(
    input  wire logic    clock, // system clock
    output trct_pkg::trct_cmd_t cmd // command access
);
    import trct_pkg::*;

    // idle port carries no stale code or data
    initial cmd = '0;

    // one command per call, valid for exactly one rising edge
    task automatic send(input logic wr, input logic [7:0] code,
                        input logic [15:0] wdata);
        @(negedge clock);
        cmd = '{valid: 1'b1, write: wr, code: code, wdata: wdata};
        @(negedge clock);
        cmd = '0;
    endtask
endmodule

/* sim/trct_region_targets_tb.sv */
`timescale 1ns/100ps
module trct_region_targets_tb;
    import trct_pkg::*;

    // ****************************************************************
    // register image, stimulus and expectation queue
    // ****************************************************************
    localparam logic [7:0]  CODES [5] = '{CMD_WARM_T6, CMD_VCODE_65,
        CMD_VCODE_432, CMD_ICODE_65, CMD_CHG_CFG};
    localparam logic [15:0] MASKS [5] = '{16'hffff, 16'h03ff, 16'h7fff,
        16'h03ff, 16'h0007};
    localparam logic [15:0] DEFS  [5] = '{16'h136a, 16'h0067, 16'h1def,
        16'h01ef, 16'h0001};

    logic               clock;
    logic               rst;
    logic               temp_valid;
    logic signed [15:0] temp_value;
    trct_cmd_t          cmd;
    trct_rsp_t          rsp_q;
    trct_thr_t          thr;
    trct_icode_t        ilow;
    logic [4:0]         vset;
    logic [4:0]         iset;
    trct_region_t       region;
    trct_tgt_t          targets;
    logic [15:0]        img [5];
    trct_rsp_t          expq [$];
    int                 errors;
    int                 checks;
    int                 i;
    int unsigned        seed;

    trct_host_model host
    (
        .clock (clock),
        .cmd   (cmd)
    );

    trct_region_targets dut
    (
        .clock       (clock),
        .rst         (rst),
        .cmd         (cmd),
        .rsp_q       (rsp_q),
        .temp_valid  (temp_valid),
        .temp_value  (temp_value),
        .thr_in      (thr),
        .icode_low   (ilow),
        .vcharge_set (vset),
        .icharge_set (iset),
        .region      (region),
        .targets     (targets)
    );

    // 25 mhz system clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ****************************************************************
    // compare tasks and reference model
    // ****************************************************************
    task automatic cmp_rsp(input trct_rsp_t exp, input trct_rsp_t got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR rsp_q expected %h seen %h", exp, got);
        end
    endtask

    task automatic cmp_val(input string name, input logic [11:0] exp,
                           input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic int idx(input logic [7:0] code);
        for (int k = 0; k < 5; k++)
            if (CODES[k] == code)
                return k;
        return -1;
    endfunction

    // equal to a threshold counts as the warmer region
    function automatic trct_region_t exp_region(logic signed [15:0] v);
        if (v > thr.t1) return REG_R1;
        if (v > thr.t2) return REG_R2;
        if (v > thr.t3) return REG_R3;
        if (v > thr.t4) return REG_R4;
        if (v > thr.t5) return REG_R5;
        if (v > $signed(img[0])) return REG_R6;
        return REG_R7;
    endfunction

    // outside regions 2..6, or disabled, the host codes stay active
    function automatic trct_tgt_t exp_tgt(trct_region_t r);
        trct_tgt_t t;
        t = '{vset, iset, 1'b0, img[4][0]};
        if (img[4][0])
            case (r)
                REG_R2: t = '{img[2][4:0], ilow.i2, 1'b0, 1'b1};
                REG_R3: t = '{img[2][9:5], ilow.i3, 1'b0, 1'b1};
                REG_R4: t = '{img[2][14:10], ilow.i4, 1'b0, 1'b1};
                REG_R5: t = '{img[1][4:0], img[3][4:0], 1'b0, 1'b1};
                REG_R6: t = '{img[1][9:5], img[3][9:5], 1'b0, 1'b1};
                default: t.suspend = 1'b1;
            endcase
        return t;
    endfunction

    // ****************************************************************
    // drivers and response monitor
    // ****************************************************************
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(negedge clock);
        for (int k = 0; k < 5; k++)
            img[k] = DEFS[k];
        rst = 1'b0;
    endtask

    // unmapped writes leave the image alone; high bits are dropped
    task automatic wr(input logic [7:0] code, input logic [15:0] d);
        int k;
        k = idx(code);
        host.send(1'b1, code, d);
        if (k >= 0)
            img[k] = d & MASKS[k];
    endtask

    task automatic rd(input logic [7:0] code);
        int k;
        k = idx(code);
        if (k >= 0)
            expq.push_back('{1'b1, 1'b0, img[k]});
        else
            expq.push_back('{1'b1, 1'b1, 16'h0000});
        host.send(1'b0, code, 16'h0000);
    endtask

    // region one edge after the strobe, targets one edge later
    task automatic temp(input logic signed [15:0] v);
        @(negedge clock);
        temp_value = v;
        temp_valid = 1'b1;
        @(negedge clock);
        temp_valid = 1'b0;
        repeat (2) @(negedge clock);
        cmp_val("region", 12'(exp_region(v)), 12'(region));
        cmp_val("targets", exp_tgt(exp_region(v)), targets);
    endtask

    // every answer must have been announced by a read
    always @(negedge clock)
        if (rsp_q.valid === 1'b1)
        begin
            if (expq.size() == 0)
                cmp_rsp('0, rsp_q);
            else
                cmp_rsp(expq.pop_front(), rsp_q);
        end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard at 20000 cycles, far beyond the roughly 200 cycles of the tests
    initial
    begin
        #(40 * 20000);
        errors++;
        $display("ERROR watchdog expected done seen hang");
        complete_run();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        rst = 1'b1;
        temp_valid = 1'b0;
        temp_value = 16'sh0000;
        errors = 0;
        checks = 0;
        seed = $urandom(32'h1512_b75a);
        thr = '{16'sd16117, 16'sd14113, 16'sd7970, 16'sd7112, 16'sd6325};
        ilow = 15'($urandom);
        vset = 5'($urandom);
        iset = 5'($urandom);
        do_reset();
        repeat (2) @(negedge clock);
        cmp_val("region", 12'(REG_R4), 12'(region));
        cmp_val("targets", exp_tgt(REG_R4), targets);
        for (i = 0; i < 5; i++)
            rd(CODES[i]);
        rd(8'h28);
        $display("test reset_values done");
        for (i = 0; i < 5; i++)
            wr(CODES[i], 16'($urandom));
        wr(8'h2a, 16'hffff);
        for (i = 0; i < 5; i++)
            rd(CODES[i]);
        rd(8'h2a);
        $display("test write_readback done");
        wr(CMD_WARM_T6, 16'h136a);
        wr(CMD_CHG_CFG, 16'h0001);
        for (i = 0; i < 5; i++)
            temp(thr[79 - 16 * i -: 16] + 16'sd1);
        temp($signed(img[0]) + 16'sd1);
        temp($signed(img[0]));
        temp(thr.t5);
        repeat (20) temp(16'($urandom_range(3000, 18000)));
        $display("test regions done");
        wr(CMD_CHG_CFG, 16'h0006);
        temp(thr.t2 + 16'sd1);
        temp(thr.t5 + 16'sd1);
        $display("test disabled done");
        do_reset();
        repeat (2) @(negedge clock);
        cmp_val("region", 12'(REG_R4), 12'(region));
        for (i = 0; i < 5; i++)
            rd(CODES[i]);
        repeat (3) @(negedge clock);
        cmp_val("pending", 12'h000, 12'(expq.size()));
        $display("test second_reset done");
        complete_run();
    end
endmodule
